//--- common/rxt_pkg.sv
package rxt_pkg;

  localparam int CLK_NS = 10;

  // register map and power-on values
  localparam logic [7:0] ADDR_NR = 8'h07;
  localparam logic [7:0] ADDR_BL = 8'h08;
  localparam logic [7:0] NR_RST  = 8'h0E;
  localparam logic [7:0] BL_RST  = 8'h1F;

  // step sizes: 512 and 128 periods of the 13.56 MHz carrier
  localparam int NR_STEP_NS  = 37760;
  localparam int BL_STEP_NS  = 9440;
  localparam int NR_STEP_CYC = NR_STEP_NS / CLK_NS;
  localparam int BL_STEP_CYC = BL_STEP_NS / CLK_NS;
  localparam int STEP_W      = 12;

  // protocol preset times
  localparam int NR_OTHER_NS = 529000;
  localparam int NR_VHI_NS   = 755000;
  localparam int NR_VLO_NS   = 1812000;
  localparam int BL_JP_NS    = 9440;
  localparam int BL_PROX_NS  = 66000;
  localparam int BL_VIC_NS   = 293000;

  // nearest whole step for a preset time
  function automatic logic [7:0] rxt_steps(input int t_ns, input int step_ns);
    return 8'((t_ns + step_ns / 2) / step_ns);
  endfunction : rxt_steps

  localparam logic [7:0] NR_OTHER = rxt_steps(NR_OTHER_NS, NR_STEP_NS);
  localparam logic [7:0] NR_VHI   = rxt_steps(NR_VHI_NS, NR_STEP_NS);
  localparam logic [7:0] NR_VLO   = rxt_steps(NR_VLO_NS, NR_STEP_NS);
  localparam logic [7:0] BL_JP    = rxt_steps(BL_JP_NS, BL_STEP_NS);
  localparam logic [7:0] BL_PROX  = rxt_steps(BL_PROX_NS, BL_STEP_NS);
  localparam logic [7:0] BL_VIC   = rxt_steps(BL_VIC_NS, BL_STEP_NS);

  // protocol selection codes; unlisted codes take the generic presets
  localparam logic [2:0] PROTO_VIC_LO = 3'h0;
  localparam logic [2:0] PROTO_VIC_HI = 3'h1;
  localparam logic [2:0] PROTO_PROX_A = 3'h2;
  localparam logic [2:0] PROTO_PROX_B = 3'h3;
  localparam logic [2:0] PROTO_JP     = 3'h4;

  typedef enum logic [1:0] {
    NR_IDLE = 2'b01,
    NR_RUN  = 2'b10
  } rxt_nr_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rxt_reg_req_s;

  typedef struct packed {
    logic       wr;
    logic [2:0] code;
  } rxt_proto_req_s;

endpackage : rxt_pkg

//--- rtl/rxt_step_tick.sv
`timescale 1ns/1ps
`default_nettype none
module rxt_step_tick
  import rxt_pkg::*;
#(
  parameter int PERIOD = NR_STEP_CYC,
  parameter int W      = STEP_W
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } rxt_tick_st_s;

  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  rxt_tick_st_s s;
  rxt_tick_st_s next_s;

  // one tick every PERIOD clocks, phase set by restart
  assign tick = (s.cnt == LAST) && !restart;

  always_comb begin
    next_s = s;
    if (restart || tick) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  tick_phase_a: assert property (@(posedge clock) disable iff (rst)
    restart |=> !tick [*2])
    else $error("step tick too soon after restart");

endmodule : rxt_step_tick
`default_nettype wire

//--- rtl/rxt_timers.sv
`timescale 1ns/1ps
`default_nettype none
module rxt_timers
  import rxt_pkg::*;
#(
  parameter int NR_STEP = NR_STEP_CYC,
  parameter int BL_STEP = BL_STEP_CYC
) (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           chip_en,
  input  wire rxt_reg_req_s   reg_req,
  input  wire rxt_proto_req_s proto_req,
  input  wire logic           tx_eof,
  input  wire logic           rx_start,
  input  wire logic           fifo_reset,
  output logic [7:0]          reg_rdata,
  output logic                no_resp_irq,
  output logic                nr_running,
  output logic                rx_dec_reset,
  output logic                rx_start_ok
);

  typedef struct packed {
    logic       en_meta;
    logic       en_sync;
    logic [7:0] nr_reg;
    logic [7:0] bl_reg;
    logic [2:0] proto;
    rxt_nr_e    nr_st;
    logic [7:0] nr_cnt;
    logic [7:0] bl_cnt;
    logic       irq;
    logic [7:0] rdata;
  } rxt_st_s;

  localparam rxt_st_s ST_RST = '{
    en_meta: 1'b0, en_sync: 1'b0, nr_reg: NR_RST, bl_reg: BL_RST,
    proto: PROTO_VIC_LO, nr_st: NR_IDLE, nr_cnt: 8'h00,
    bl_cnt: 8'h00, irq: 1'b0, rdata: 8'h00};

  rxt_st_s s;
  rxt_st_s next_s;
  logic    nr_tick;
  logic    bl_tick;
  logic    vic;
  logic    blanking;

  ////////////////////////////////////////////////////////////////////
  // step dividers, both phased to the end of the transmit frame

  rxt_step_tick #(.PERIOD(NR_STEP), .W(STEP_W)) nr_div (
    .clock   (clock),
    .rst     (rst),
    .restart (tx_eof),
    .tick    (nr_tick)
  );

  rxt_step_tick #(.PERIOD(BL_STEP), .W(STEP_W)) bl_div (
    .clock   (clock),
    .rst     (rst),
    .restart (tx_eof),
    .tick    (bl_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign vic          = (s.proto == PROTO_VIC_LO) || (s.proto == PROTO_VIC_HI);
  assign blanking     = (s.bl_cnt != 8'h00);
  assign rx_dec_reset = blanking;
  // the eof cycle itself also masks, the blanking count is not loaded yet
  assign rx_start_ok  = rx_start && !blanking && !tx_eof;
  assign no_resp_irq  = s.irq;
  assign nr_running   = (s.nr_st == NR_RUN);
  assign reg_rdata    = s.rdata;

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s         = s;
    next_s.en_meta = chip_en;
    next_s.en_sync = s.en_meta;
    next_s.irq     = 1'b0;
    // read data latched on the strobe, unmapped reads give zero
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_NR: next_s.rdata = s.nr_reg;
        ADDR_BL: next_s.rdata = s.bl_reg;
        default: next_s.rdata = 8'h00;
      endcase
    end
    if (!s.en_sync) begin
      // chip disabled: registers back to power-on values, timers stop
      next_s.nr_reg = NR_RST;
      next_s.bl_reg = BL_RST;
      next_s.nr_st  = NR_IDLE;
      next_s.nr_cnt = 8'h00;
      next_s.bl_cnt = 8'h00;
    end else begin
      // protocol selection overrides a same-cycle host write
      if (proto_req.wr) begin
        next_s.proto = proto_req.code;
        unique case (proto_req.code)
          PROTO_VIC_HI: next_s.nr_reg = NR_VHI;
          PROTO_VIC_LO: next_s.nr_reg = NR_VLO;
          default:      next_s.nr_reg = NR_OTHER;
        endcase
        unique case (proto_req.code)
          PROTO_JP:                   next_s.bl_reg = BL_JP;
          PROTO_PROX_A, PROTO_PROX_B: next_s.bl_reg = BL_PROX;
          PROTO_VIC_LO, PROTO_VIC_HI: next_s.bl_reg = BL_VIC;
          default:                    next_s.bl_reg = BL_RST;
        endcase
      end else if (reg_req.wr) begin
        if (reg_req.addr == ADDR_NR) begin
          next_s.nr_reg = reg_req.wdata;
        end
        if (reg_req.addr == ADDR_BL) begin
          next_s.bl_reg = reg_req.wdata;
        end
      end
      // blanking count in 9.44 us steps from end of frame
      if (tx_eof) begin
        next_s.bl_cnt = s.bl_reg;
      end else if (bl_tick && blanking) begin
        next_s.bl_cnt = s.bl_cnt - 8'h01;
      end
      // no-response slot timer; value zero leaves it off
      unique case (s.nr_st)
        NR_IDLE: begin
          if (tx_eof && vic && (s.nr_reg != 8'h00)) begin
            next_s.nr_st  = NR_RUN;
            next_s.nr_cnt = s.nr_reg;
          end
        end
        NR_RUN: begin
          if (tx_eof) begin
            next_s.nr_cnt = s.nr_reg;
            if (!vic || (s.nr_reg == 8'h00)) begin
              next_s.nr_st = NR_IDLE;
            end
          end else if (rx_start_ok || fifo_reset) begin
            next_s.nr_st = NR_IDLE;
          end else if (nr_tick) begin
            if (s.nr_cnt == 8'h01) begin
              next_s.nr_st = NR_IDLE;
              next_s.irq   = vic;
            end else begin
              next_s.nr_cnt = s.nr_cnt - 8'h01;
            end
          end
        end
        default: begin
          next_s.nr_st = NR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checking helpers: cycles since end of frame, values loaded there

  logic [19:0] cyc;
  logic [7:0]  nr_load;
  logic [7:0]  bl_load;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cyc     <= 20'h00000;
      nr_load <= 8'h00;
      bl_load <= 8'h00;
    end else if (tx_eof) begin
      cyc     <= 20'h00000;
      nr_load <= s.nr_reg;
      bl_load <= s.bl_reg;
    end else if (cyc != 20'hFFFFF) begin
      cyc <= cyc + 20'h00001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  dis_reload_a: assert property (
    !s.en_sync |=> (s.nr_reg == 8'h0E) && (s.bl_reg == 8'h1F))
    else $error("registers not reloaded while disabled");

  vhi_preset_a: assert property (
    s.en_sync && proto_req.wr && (proto_req.code == PROTO_VIC_HI)
    |=> s.nr_reg == 8'h14)
    else $error("vicinity high rate preset wrong");

  jp_blank_a: assert property (
    s.en_sync && proto_req.wr && (proto_req.code == PROTO_JP)
    |=> (s.bl_reg == 8'h01) && (s.proto == PROTO_JP))
    else $error("blanking preset wrong");

  blank_hold_a: assert property (
    s.en_sync && tx_eof && (s.bl_reg != 8'h00)
    |=> rx_dec_reset && !rx_start_ok)
    else $error("decoders not held after frame end");

  blank_len_a: assert property (
    s.en_sync && $fell(rx_dec_reset) && !$past(tx_eof)
    |-> cyc == 20'(bl_load) * 20'(BL_STEP))
    else $error("blanking length wrong");

  nr_len_a: assert property (
    no_resp_irq |-> cyc == 20'(nr_load) * 20'(NR_STEP))
    else $error("no-response time wrong");

  irq_vic_a: assert property (
    no_resp_irq |-> vic && $past(s.nr_st) == NR_RUN)
    else $error("no-response interrupt outside vicinity run");

  rx_stop_a: assert property (
    nr_running && rx_start_ok |=> !nr_running ##1 !no_resp_irq)
    else $error("timer kept running after response");

  fifo_off_a: assert property (
    nr_running && fifo_reset && !tx_eof |=> !no_resp_irq [*2])
    else $error("fifo reset did not disable detection");

  irq_pulse_a: assert property (
    no_resp_irq |=> !no_resp_irq && !nr_running)
    else $error("interrupt not a single pulse");

  irq_seen_c:   cover property (no_resp_irq);
  resp_seen_c:  cover property (nr_running && rx_start_ok);
  fifo_seen_c:  cover property (nr_running && fifo_reset);
  blank_seen_c: cover property ($fell(rx_dec_reset) && s.en_sync);

endmodule : rxt_timers
`default_nettype wire

//--- verification/rxt_host.sv
`timescale 1ns/1ps
`default_nettype none
module rxt_host
  import rxt_pkg::*;
(
  input  wire logic    clock,
  output rxt_reg_req_s reg_req,
  output logic         fifo_reset
);
  // bus idle and command line low from time zero
  initial begin
    reg_req = '0;
    fifo_reset = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-cycle register strobe; read data is valid when this returns
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    @(posedge clock) #1;
    reg_req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge clock) #1;
    reg_req = '0;
  endtask : access

  // fifo reset command, only issued after tx complete
  task automatic flush();
    @(posedge clock) #1;
    fifo_reset = 1'b1;
    @(posedge clock) #1;
    fifo_reset = 1'b0;
  endtask : flush
endmodule : rxt_host
`default_nettype wire

//--- verification/rx_response_timers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rx_response_timers_tb import rxt_pkg::*;;
  localparam int NS = 8;
  localparam int BS = 4;
  logic           clock = 1'b0;
  logic           rst, chip_en, tx_eof, rx_start, fifo_reset;
  rxt_reg_req_s   reg_req;
  rxt_proto_req_s proto_req;
  logic           no_resp_irq, nr_running, rx_dec_reset, rx_start_ok;
  logic [7:0]     reg_rdata;
  int             n_fail, checked, cyc, n_blank, irq_at, n_ok, tmo, nr_m, bl_m, pr_m, seed;

  always #5 clock = ~clock;

  // short steps keep the run brief; expectations scale with them
  rxt_timers #(.NR_STEP(NS), .BL_STEP(BS)) i_rxt_timers (.clock, .rst, .chip_en, .reg_req, .proto_req,
    .tx_eof, .rx_start, .fifo_reset, .reg_rdata, .no_resp_irq, .nr_running, .rx_dec_reset, .rx_start_ok);
  rxt_host i_rxt_host (.clock, .reg_req, .fifo_reset);

  //////////////////////////////////////////////////////////////////////////////
  // edges since the eof edge, blanking length, irq moment
  // sampled on the falling edge so outputs launched at the rising edge have settled
  always @(negedge clock) begin
    if (tx_eof) begin
      cyc <= 0;
      n_blank <= 0;
      irq_at <= 0;
      n_ok <= 0;
    end else begin
      cyc <= cyc + 1;
      n_blank <= n_blank + int'(rx_dec_reset);
      n_ok <= n_ok + int'(rx_start_ok);
      if (no_resp_irq === 1'b1)
        irq_at <= cyc;
    end
  end

  // hang guard, far above the expected few hundred cycles
  always @(posedge clock) begin
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      n_fail++;
      close_out();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic int stp(input int t, input int s);
    return (t + s / 2) / s; // nearest whole step, both in 10 ns units
  endfunction : stp

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] a, input int exp);
    i_rxt_host.access(1'b0, a, 8'h00);
    check($sformatf("reg %h", a), 16'(reg_rdata), 16'(exp));
  endtask : rdchk

  task automatic wr(input logic [7:0] a, input int d);
    i_rxt_host.access(1'b1, a, 8'(d));
    if (a == ADDR_NR)
      nr_m = d;
    if (a == ADDR_BL)
      bl_m = d;
  endtask : wr

  task automatic proto(input int c);
    @(posedge clock) #1;
    proto_req = '{1'b1, 3'(c)};
    @(posedge clock) #1;
    proto_req = '0;
    pr_m = c;
    nr_m = (c == 1) ? stp(75500, 3776) : (c == 0) ? stp(181200, 3776) : stp(52900, 3776);
    bl_m = (c == 4) ? stp(944, 944) : (c == 2 || c == 3) ? stp(6600, 944) : stp(29300, 944);
  endtask : proto

  task automatic pulse(input int w);
    @(posedge clock) #1;
    {tx_eof, rx_start} = 2'(w);
    @(posedge clock) #1;
    {tx_eof, rx_start} = 2'b00;
  endtask : pulse

  // modes: plain, reply after blanking, fifo reset, reply inside blanking
  task automatic xchg(input int m);
    pulse(2);
    check("run", 16'(nr_running), 16'(pr_m < 2));
    if (m == 1) begin
      repeat (bl_m * BS) @(posedge clock);
      pulse(1);
    end
    if (m == 2)
      i_rxt_host.flush();
    if (m == 3)
      pulse(1);
    repeat (nr_m * NS + 12) @(posedge clock);
    check("blank", 16'(n_blank), 16'(bl_m * BS));
    check("rx ok", 16'(n_ok), 16'(m == 1));
    check("irq", 16'(irq_at), 16'((pr_m < 2 && m != 1 && m != 2) ? nr_m * NS : 0));
    check("stop", 16'(nr_running), 16'(0));
  endtask : xchg

  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h7A77AD79;
    rst = 1'b1;
    chip_en = 1'b1;
    tx_eof = 1'b0;
    rx_start = 1'b0;
    proto_req = '0;
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
    rdchk(ADDR_NR, 8'h0E);
    rdchk(ADDR_BL, 8'h1F);
    wr(8'h09, 8'h55);
    rdchk(8'h09, 0);
    for (int c = 0; c < 8; c++) begin
      proto(c);
      rdchk(ADDR_NR, nr_m);
      rdchk(ADDR_BL, bl_m);
    end
    for (int p = 0; p < 3; p += 2) begin
      proto(p);
      wr(ADDR_NR, 2 + $unsigned($random(seed)) % 2);
      wr(ADDR_BL, 1 + $unsigned($random(seed)) % 2);
      rdchk(ADDR_NR, nr_m);
      rdchk(ADDR_BL, bl_m);
      for (int m = 0; m < 4; m++)
        xchg(m);
    end
    @(posedge clock) #1;
    chip_en = 1'b0;
    repeat (4) @(posedge clock);
    #1 chip_en = 1'b1;
    repeat (3) @(posedge clock);
    rdchk(ADDR_NR, 8'h0E);
    rdchk(ADDR_BL, 8'h1F);
    close_out();
  end
endmodule : rx_response_timers_tb
`default_nettype wire
